// ---- include/sarr_link_if.sv ----
// Carrier between the system-clock side and the external-clock shifter
`timescale 1ns/10ps

interface sarr_link_if;
  import sarr_pkg::*;

  sarr_word_t word;   // Held result word, stable outside the update
  logic       clr;    // One flop, clears the shifter when a new word lands
  logic       sdo;    // Serial bit produced on the external clock

  // System side drives the word and clear
  modport sys  (output word, output clr, input sdo);
  // Link side shifts and answers with the serial bit
  modport link (input word, input clr, output sdo);
endinterface

// ---- include/sarr_map.svh ----
// Constants of the conversion result readout: timing counts, widths and reset values
`ifndef SARR_MAP_SVH
`define SARR_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and conversion timing
// ----------------------------------------------------------------------------
`define SARR_CLK_NS        100
`define SARR_CONV_NS       18000
`define SARR_CONV_CYC      (`SARR_CONV_NS / `SARR_CLK_NS)
`define SARR_HOLD_NS       12000
`define SARR_HOLD_CYC      (`SARR_HOLD_NS / `SARR_CLK_NS)
`define SARR_BUSY_NS       85
`define SARR_BUSY_CYC      (((`SARR_BUSY_NS / `SARR_CLK_NS) < 1) ? 1 : (`SARR_BUSY_NS / `SARR_CLK_NS))

// ----------------------------------------------------------------------------
// Internal serial data clock timing
// ----------------------------------------------------------------------------
`define SARR_LEAD_NS       1400
`define SARR_LEAD_CYC      (`SARR_LEAD_NS / `SARR_CLK_NS)
`define SARR_DCLK_NS       1100
`define SARR_DCLK_CYC      (`SARR_DCLK_NS / `SARR_CLK_NS)
`define SARR_DCLK_HI_CYC   (`SARR_DCLK_CYC / 2)
`define SARR_RISE_PC       3

// ----------------------------------------------------------------------------
// Widths, positions and reset values
// ----------------------------------------------------------------------------
`define SARR_BITS          16
`define SARR_MSB           15
`define SARR_RESULT_RST    16'h0000
`define SARR_TAG_DEPTH     16

`endif

// ---- include/sarr_pkg.sv ----
// Types shared by the conversion result readout modules
package sarr_pkg;

  // Result word as seen on the outputs
  typedef logic [15:0] sarr_word_t;

  // Conversion sequencer states
  typedef enum logic [0:0] {
    SARR_IDLE,
    SARR_CONV
  } sarr_conv_t;

  // Internal serial clock sequencer states
  typedef enum logic [1:0] {
    SARR_TX_IDLE,
    SARR_TX_LEAD,
    SARR_TX_BITS
  } sarr_tx_t;

endpackage

// ---- rtl/sarr_link_shift.sv ----
// Serial shifter that runs on the externally supplied data clock
`timescale 1ns/10ps
`include "sarr_map.svh"

module sarr_link_shift (
  // Link clock and chain input
  input  wire logic  link_clk_in,
  input  wire logic  chain_in,
  // Carrier to the system side
  sarr_link_if.link  lk
);
  import sarr_pkg::*;

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  logic                        chain_r;   // Chain bit taken on the rising edge
  logic [4:0]                  cnt_r;     // Falling edges since the word landed
  logic [`SARR_TAG_DEPTH-1:0]  tsh_r;     // Chain bits waiting behind the word
  logic                        sdo_r;     // Serial bit, changes on falling edges

  // Clear comes from a single system flop, so it is glitch free
  // Chain input is sampled once per pulse on the rising edge
  always_ff @(posedge link_clk_in or posedge lk.clr) begin
    if (lk.clr) begin
      chain_r <= 1'b0;
    end else begin
      chain_r <= chain_in;
    end
  end

  // Counter saturates, so chain bits keep flowing until the next clear
  always_ff @(negedge link_clk_in or posedge lk.clr) begin
    if (lk.clr) begin
      cnt_r <= 5'h00;
    end else if (cnt_r != 5'h10) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // Chain bits enter one per pulse and leave sixteen pulses later
  always_ff @(negedge link_clk_in or posedge lk.clr) begin
    if (lk.clr) begin
      tsh_r <= '0;
    end else begin
      tsh_r <= {tsh_r[`SARR_TAG_DEPTH-2:0], chain_r};
    end
  end

  // Word is quasi-static here: it only moves while the link must be idle
  always_ff @(negedge link_clk_in or posedge lk.clr) begin
    if (lk.clr) begin
      sdo_r <= 1'b0;
    end else if (cnt_r[4] == 1'b0) begin
      sdo_r <= lk.word[~cnt_r[3:0]];
    end else begin
      sdo_r <= tsh_r[`SARR_TAG_DEPTH-1];
    end
  end

  assign lk.sdo = sdo_r;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  msb_first_a : assert property (@(negedge link_clk_in) disable iff (lk.clr)
    (cnt_r == 5'h00) |=> (sdo_r == $past(lk.word[15]) && cnt_r == 5'h01))
    else $error("First falling edge did not present the top bit");

  chain_pass_a : assert property (@(negedge link_clk_in) disable iff (lk.clr)
    (cnt_r == 5'h10) |=> (sdo_r == $past(tsh_r[15]) && cnt_r == 5'h10))
    else $error("Chain bit not forwarded after the word");

endmodule // sarr_link_shift

// ---- rtl/sarr_readout.sv ----
// Result readout of the sampling converter: parallel bus, internal and external serial clocking
`timescale 1ns/10ps
`include "sarr_map.svh"

module sarr_readout (
  // System clock and reset
  input  wire logic               clk_sys_in,
  input  wire logic               rst_n_in,
  // Control pins from the host
  input  wire logic               chip_select_n_in,
  input  wire logic               read_convert_in,
  input  wire logic               clock_source_sel_in,
  input  wire logic               byte_half_sel_in,
  input  wire logic               output_coding_select_in,
  input  wire logic               chain_in,
  // Result from the conversion engine, straight binary
  input  wire sarr_pkg::sarr_word_t conv_code_in,
  // Serial data clock pin, two-way
  input  wire logic               serial_data_clock_in,
  output logic                    serial_data_clock_out,
  output logic                    serial_data_clock_oe_out,
  // Serial data and busy
  output logic                    serial_out_line_out,
  output logic                    busy_n_out,
  // Parallel data bus, three-state
  output logic [7:0]              parallel_data_bus_out,
  output logic                    parallel_data_bus_oe_out
);
  import sarr_pkg::*;

  // ----------------------------------------------------------------------------
  // Timing constants for the checks and the internal transmit sequencer
  // ----------------------------------------------------------------------------
  localparam int CONV_CYC_I = `SARR_CONV_CYC;
  localparam int LEAD_I     = `SARR_LEAD_CYC - `SARR_RISE_PC;

  // ----------------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------------
  logic       rst_meta_r;   // First reset stage
  logic       rst_n_r;      // Released reset for the whole design
  logic [5:0] pin_meta_r;   // First stage, read by the second only
  logic [5:0] pin_sync_r;   // Second stage, safe to use
  logic       cs_n_s;       // Synchronised chip select
  logic       rc_s;         // Synchronised read/convert
  logic       ext_s;        // Synchronised clock source select
  logic       byte_s;       // Synchronised byte half select
  logic       sb_s;         // Synchronised coding select
  logic       chain_s;      // Synchronised chain input

  // Asynchronous assert, two-flop release
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Pins are asynchronous to the system clock, so each passes two flops
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_meta_r <= 6'h03;
      pin_sync_r <= 6'h03;
    end else begin
      pin_meta_r <= {chain_in, output_coding_select_in, byte_half_sel_in,
                     clock_source_sel_in, read_convert_in, chip_select_n_in};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign cs_n_s  = pin_sync_r[0];
  assign rc_s    = pin_sync_r[1];
  assign ext_s   = pin_sync_r[2];
  assign byte_s  = pin_sync_r[3];
  assign sb_s    = pin_sync_r[4];
  assign chain_s = pin_sync_r[5];

  // ----------------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------------
  sarr_conv_t conv_st_r;    // Idle or converting
  logic [7:0] conv_cnt_r;   // Cycles since the start
  logic       busy_n_r;     // Busy, low while converting
  logic       start_req;    // Both controls low
  logic       start_ok;     // Request accepted
  logic       upd_now;      // Output register refresh cycle
  sarr_word_t result_r;     // Output register, already coded
  logic       link_clr_r;   // Clears the external shifter on refresh, holds it in internal mode

  assign start_req = !cs_n_s && !rc_s;
  // Requests while busy are simply not looked at
  assign start_ok  = (conv_st_r == SARR_IDLE) && start_req;
  // Refresh one cycle before busy rises, well after the hold window
  assign upd_now   = (conv_st_r == SARR_CONV) && (conv_cnt_r == 8'(`SARR_CONV_CYC - 2));

  // Sequencer state and cycle count
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      conv_st_r  <= SARR_IDLE;
      conv_cnt_r <= 8'h00;
    end else begin
      unique case (conv_st_r)
        SARR_IDLE: begin
          if (start_ok) begin
            conv_st_r  <= SARR_CONV;
            conv_cnt_r <= 8'h00;
          end
        end
        SARR_CONV: begin
          if (conv_cnt_r == 8'(`SARR_CONV_CYC - 1)) begin
            conv_st_r <= SARR_IDLE;
          end
          conv_cnt_r <= conv_cnt_r + 8'h01;
        end
      endcase
    end
  end

  // Busy falls on the first edge after the request is seen.
  // Pin synchronisation adds two cycles ahead of this edge.
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      busy_n_r <= 1'b1;
    end else if (start_ok) begin
      busy_n_r <= 1'b0;
    end else if ((conv_st_r == SARR_CONV) && (conv_cnt_r == 8'(`SARR_CONV_CYC - 1))) begin
      busy_n_r <= 1'b1;
    end
  end

  // Coding is applied at refresh; two's complement flips the top bit
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      result_r <= `SARR_RESULT_RST;
    end else if (upd_now) begin
      result_r <= {conv_code_in[`SARR_MSB] ~^ sb_s, conv_code_in[`SARR_MSB-1:0]};
    end
  end

  // Single flop clear; held in internal mode so our own clock pulses never advance the shifter
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      link_clr_r <= 1'b1;
    end else begin
      link_clr_r <= upd_now || !ext_s;
    end
  end

  // ----------------------------------------------------------------------------
  // Parallel bus
  // ----------------------------------------------------------------------------
  logic [7:0] pbus_r;       // Selected byte
  logic       pbus_oe_r;    // Bus drive enable

  // Reading never disturbs the output register
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pbus_r <= 8'h00;
    end else begin
      pbus_r <= byte_s ? result_r[7:0] : result_r[15:8];
    end
  end

  // Driven only for select low with read high, whatever the serial mode
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pbus_oe_r <= 1'b0;
    end else begin
      pbus_oe_r <= !cs_n_s && rc_s;
    end
  end

  // ----------------------------------------------------------------------------
  // Internal serial data clock
  // ----------------------------------------------------------------------------
  sarr_tx_t   tx_st_r;      // Internal transmit state
  logic [3:0] tx_pc_r;      // Position inside one clock period
  logic [3:0] tx_bit_r;     // Bits already sent
  sarr_word_t tx_word_r;    // Copy of the previous result being sent
  logic       tag_hold_r;   // Chain level sensed at transmission start
  logic       dclk_r;       // Generated data clock
  logic       dclk_oe_r;    // Data clock pin driven in internal mode
  logic       int_sdo_r;    // Serial bit in internal mode
  logic       tx_last;      // End of the sixteenth period
  logic       ser_out_r;    // Mode select, high when the external clock drives the serial line

  assign tx_last = (tx_st_r == SARR_TX_BITS) && (tx_pc_r == 4'(`SARR_DCLK_CYC - 1)) &&
                   (tx_bit_r == 4'(`SARR_BITS - 1));

  // Start copies the previous result, so the refresh during conversion is harmless
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tx_st_r    <= SARR_TX_IDLE;
      tx_pc_r    <= 4'h0;
      tx_bit_r   <= 4'h0;
      tx_word_r  <= `SARR_RESULT_RST;
      tag_hold_r <= 1'b0;
    end else if (start_ok && !ext_s) begin
      tx_st_r    <= SARR_TX_LEAD;
      tx_pc_r    <= 4'h0;
      tx_bit_r   <= 4'h0;
      tx_word_r  <= result_r;
      tag_hold_r <= chain_s;
    end else begin
      unique case (tx_st_r)
        SARR_TX_IDLE: begin
          tx_pc_r <= 4'h0;
        end
        SARR_TX_LEAD: begin
          if (tx_pc_r == 4'(LEAD_I - 1)) begin
            tx_st_r <= SARR_TX_BITS;
            tx_pc_r <= 4'h0;
          end else begin
            tx_pc_r <= tx_pc_r + 4'h1;
          end
        end
        SARR_TX_BITS: begin
          if (tx_pc_r == 4'(`SARR_DCLK_CYC - 1)) begin
            tx_pc_r  <= 4'h0;
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_last) begin
              tx_st_r <= SARR_TX_IDLE;
            end
          end else begin
            tx_pc_r <= tx_pc_r + 4'h1;
          end
          if (tx_pc_r == 4'h0) begin
            tx_word_r <= {tx_word_r[`SARR_MSB-1:0], 1'b0};
          end
        end
        default: begin
          tx_st_r <= SARR_TX_IDLE;
        end
      endcase
    end
  end

  // High for part of the period, low otherwise and when idle
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dclk_r <= 1'b0;
    end else begin
      dclk_r <= (tx_st_r == SARR_TX_BITS) && (tx_pc_r >= 4'(`SARR_RISE_PC)) &&
                (tx_pc_r < 4'(`SARR_RISE_PC + `SARR_DCLK_HI_CYC));
    end
  end

  // Bit changes mid low phase, clear of both clock edges
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      int_sdo_r <= 1'b0;
    end else if (tx_last) begin
      int_sdo_r <= tag_hold_r;
    end else if ((tx_st_r == SARR_TX_BITS) && (tx_pc_r == 4'h0)) begin
      int_sdo_r <= tx_word_r[`SARR_MSB];
    end
  end

  // Pin is an input while the host supplies the clock
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dclk_oe_r <= 1'b0;
    end else begin
      dclk_oe_r <= !ext_s;
    end
  end

  // Mode select held in a flop; the pin mux below is the only gate on the path
  always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ser_out_r <= 1'b0;
    end else begin
      ser_out_r <= ext_s;
    end
  end

  // ----------------------------------------------------------------------------
  // External clock shifter
  // ----------------------------------------------------------------------------
  sarr_link_if link_bus ();

  assign link_bus.word = result_r;
  assign link_bus.clr  = link_clr_r;

  // Each of the first sixteen host clock pulses moves the serial line to the next bit of the output register; later pulses forward chain bits
  sarr_link_shift u_link (
    .link_clk_in (serial_data_clock_in),
    .chain_in    (chain_in),
    .lk          (link_bus.link)
  );

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  // Serial line has no enable: it always drives one source or the other
  assign serial_out_line_out      = ser_out_r ? link_bus.sdo : int_sdo_r;
  assign serial_data_clock_out    = dclk_r;
  assign serial_data_clock_oe_out = dclk_oe_r;
  assign busy_n_out               = busy_n_r;
  assign parallel_data_bus_out    = pbus_r;
  assign parallel_data_bus_oe_out = pbus_oe_r;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  busy_fall_a : assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
    ((conv_st_r == SARR_IDLE) && start_req) |=> !busy_n_r)
    else $error("Busy did not fall after an accepted start");

  busy_length_a : assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
    $fell(busy_n_r) |-> ##(CONV_CYC_I - 1) !busy_n_r ##1 busy_n_r)
    else $error("Busy low time differs from the conversion time");

  start_ignored_a : assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
    (!busy_n_r && start_req && conv_cnt_r < 8'(`SARR_CONV_CYC - 1)) |=> !busy_n_r && $stable(conv_st_r))
    else $error("Start request disturbed a running conversion");

  refresh_first_a : assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
    $rose(busy_n_r) |-> $past(link_clr_r) && $stable(result_r))
    else $error("Busy rose without a refreshed output register");

  hold_prev_a : assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
    ((conv_st_r == SARR_CONV) && conv_cnt_r < 8'(`SARR_HOLD_CYC)) |=> $stable(result_r))
    else $error("Previous result changed inside the hold window");

  coding_a : assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
    upd_now |=> (result_r[15] == ($past(conv_code_in[15]) ~^ $past(sb_s))) &&
                (result_r[14:0] == $past(conv_code_in[14:0])))
    else $error("Output coding does not follow the select");

  bus_enable_a : assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
    (cs_n_s || !rc_s) |=> !parallel_data_bus_oe_out)
    else $error("Parallel bus driven outside select-and-read");

  lead_quiet_a : assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
    (start_ok && !ext_s) |=> !dclk_r [*8])
    else $error("Internal clock pulsed too early after start");

  tx_tail_a : assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
    tx_last |=> (int_sdo_r == $past(tag_hold_r)) && !dclk_r ##1 !dclk_r)
    else $error("Line or clock wrong after the sixteenth pulse");

endmodule // sarr_readout

// ---- tb/sarr_host.sv ----
// Host model: clocks the serial line from outside and collects bits
`timescale 1ns/10ps

module sarr_host (
  // Link clock toward the device, low outside frames
  output logic      dclk_out,
  // Serial data from the device
  input  wire logic serial_out_line_in
);
  initial dclk_out = 1'b0;

  // ----
  // Frame of n pulses; period 80 ns, high 32 ns (40 % duty)
  // ----
  // Bit after fall k-1 is sampled at rise k, so rise 1 takes nothing
  task automatic read_frame(input int n, output logic [16:0] bits);
    bits = '0;
    #7; // Free phase against the system clock
    for (int k = 1; k <= n; k++) begin
      #48 dclk_out = 1'b1;
      if (k > 1) begin
        bits = {bits[15:0], serial_out_line_in};
      end
      #32 dclk_out = 1'b0;
    end
  endtask
endmodule // sarr_host

// ---- tb/sarr_readout_tb.sv ----
// Self-checking bench for the conversion result readout
`timescale 1ns/10ps

module sarr_readout_tb;
  import sarr_pkg::*;
  // ----
  // Signals
  // ----
  logic        clk, rst_n, cs_n, rc, ext_sel, byte_sel, coding, chain;
  sarr_word_t  code;     // Engine result
  logic        dclk_o, dclk_oe, sdo, busy_n, bus_oe, host_clk, dclk_pin;
  logic [7:0]  bus;      // Parallel byte
  logic [16:0] got;      // Collected serial bits
  int          n_mismatch, tests_run;
  time         t0, t1;   // Start and busy rise of a conversion
  // Two-way clock pin resolved from both drivers
  assign dclk_pin = dclk_oe ? dclk_o : host_clk;
  always @(posedge busy_n) t1 = $time;

  sarr_readout DUT (.clk_sys_in(clk), .rst_n_in(rst_n), .chip_select_n_in(cs_n), .read_convert_in(rc),
    .clock_source_sel_in(ext_sel), .byte_half_sel_in(byte_sel), .output_coding_select_in(coding),
    .chain_in(chain), .conv_code_in(code), .serial_data_clock_in(dclk_pin), .serial_data_clock_out(dclk_o),
    .serial_data_clock_oe_out(dclk_oe), .serial_out_line_out(sdo), .busy_n_out(busy_n),
    .parallel_data_bus_out(bus), .parallel_data_bus_oe_out(bus_oe));
  sarr_host host (.dclk_out(host_clk), .serial_out_line_in(sdo));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----
  // Tasks
  // ----
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Both bytes through the parallel bus; sync plus register needs 3 edges
  task automatic read_bytes(input sarr_word_t w);
    cs_n <= 1'b0;
    rc <= 1'b1;
    byte_sel <= 1'b0;
    cyc(5);
    check(bus_oe, 1'b1);
    check(bus, w[15:8]);
    byte_sel <= 1'b1;
    cyc(5);
    check(bus, w[7:0]);
  endtask
  // Internal clock conversion; the frame carries the previous word
  task automatic convert(input sarr_word_t nxt, input logic cod, input sarr_word_t prev);
    code <= nxt;
    coding <= cod;
    byte_sel <= 1'b0;
    rc <= 1'b0;
    t0 = $time;
    cyc(4);
    check(busy_n, 1'b0);
    rc <= 1'b1;
    cyc(5);
    check(bus, prev[15:8]);
    rc <= 1'b0; // Short start request while busy must be ignored
    cyc(2);
    rc <= 1'b1;
    for (int k = 15; k >= 0; k--) begin
      @(posedge dclk_o);
      got[k] = sdo;
    end
    check(got[15:0], prev);
    @(negedge dclk_o);
    cyc(15);
    check(sdo, chain);
    check(dclk_o, 1'b0);
    check(busy_n, 1'b1);
    check((t1 - t0 >= 12000) && (t1 - t0 <= 20000), 1'b1);
    check(t1 - t0 == 18300, 1'b1);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    rst_n = 1'b0;
    cs_n = 1'b1;
    rc = 1'b1;
    ext_sel = 1'b0;
    byte_sel = 1'b0;
    coding = 1'b1;
    chain = 1'b1;
    code = 16'h0000;
    n_mismatch = 0;
    tests_run = 0;
    cyc(20);
    rst_n <= 1'b1;
    cyc(4);
    check(bus_oe, 1'b0);
    cs_n <= 1'b0;
    convert(16'hA5C3, 1'b1, 16'h0000);
    read_bytes(16'hA5C3);
    convert(16'h1234, 1'b0, 16'hA5C3);
    read_bytes(16'h9234);
    // External clock only after busy rose, keeping off the update window
    ext_sel <= 1'b1;
    chain <= 1'b0;
    cyc(5);
    check(dclk_oe, 1'b0);
    host.read_frame(18, got);
    check(got, {16'h9234, 1'b0});
    chain <= 1'b1;
    cyc(1);
    host.read_frame(20, got);
    check(got, 17'h00007);
    check(sdo === 1'bz, 1'b0);
    cs_n <= 1'b1;
    cyc(5);
    check(bus_oe, 1'b0);
    complete_run();
  end
  // Watchdog: the sequence needs well under 1000 cycles
  initial begin
    cyc(3000);
    n_mismatch++;
    complete_run();
  end
endmodule // sarr_readout_tb
